// file: nco_pkg.sv
// package: register map, field positions and reset values for the oscillator output
package nco_pkg;
	localparam logic [3:0] NCO_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] NCO_ADDR_CLKCFG = 4'h1;
	localparam logic [3:0] NCO_ADDR_INC    = 4'h2;
	localparam logic [3:0] NCO_ADDR_ACC    = 4'h3;
	localparam logic [3:0] NCO_ADDR_IRQST  = 4'h4;
	localparam logic [3:0] NCO_ADDR_IRQEN  = 4'h5;
	localparam logic [3:0] NCO_ADDR_INTCTL = 4'h6;
	localparam logic [3:0] NCO_ADDR_APF    = 4'h7;
	localparam logic [3:0] NCO_ADDR_SRCDIV = 4'h8;
	// control register fields
	localparam int NCO_CTRL_EN   = 7;
	localparam int NCO_CTRL_OUT  = 5;
	localparam int NCO_CTRL_POL  = 4;
	localparam int NCO_CTRL_PFM  = 0;
	// clock configuration fields
	localparam int NCO_CLK_PWS_LSB = 5;
	localparam int NCO_CLK_SRC_LSB = 0;
	localparam logic [1:0] NCO_SRC_HFINT = 2'h0;
	// interrupt fields and reset values
	localparam int NCO_IRQ_OVF = 0;
	localparam int NCO_IRQ_POL = 1;
	localparam int NCO_INT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int NCO_INT_GIE  = 7;
	localparam logic [7:0]  NCO_RST_BYTE = 8'h00;
	localparam logic [31:0] NCO_RST_WORD = 32'h0000_0000;
endpackage : nco_pkg

// file: nco_pulse_timer.sv
// pulse-width timer for pulse-frequency mode
`timescale 1ns/100ps
module nco_pulse_timer (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       start,
	input  wire logic [2:0] width_sel,
	output logic            active
);
	logic [7:0] remain;
	logic [7:0] load_val;
	// width field n gives 2^n source periods
	assign load_val = 8'h01 << width_sel;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			remain <= 8'h00;
		end else if (tick) begin
			if (start)
				remain <= load_val;
			else if (remain != 8'h00)
				remain <= remain - 8'h01;
		end
	end
	assign active = (remain != 8'h00);
endmodule : nco_pulse_timer

// file: nco_out.sv
// oscillator output stage with accumulator, modes, polarity, irq and avalon slave
`timescale 1ns/100ps
module nco_out #(
	parameter int ACC_W = 20
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        sleep_mode,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             nco_output,
	output logic             nco_to_logic_cell,
	output logic             nco_to_waveform_unit,
	output logic             nco_pin_primary,
	output logic             nco_pin_alternate,
	output logic             hf_osc_keep_on,
	output logic             irq
);
	logic rst_meta, rst_n;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	logic [7:0]       ctrl;
	logic [7:0]       clkcfg;
	logic [ACC_W-1:0] inc;
	logic [ACC_W-1:0] acc;
	logic [1:0]       irq_st;
	logic [1:0]       irq_en;
	logic [7:0]       intctl;
	logic             apf;
	logic [7:0]       srcdiv;
	logic [7:0]       div_cnt;
	logic             raw_q;
	logic             pol_d;
	logic             ack;

	wire en        = ctrl[nco_pkg::NCO_CTRL_EN];
	wire pfm       = ctrl[nco_pkg::NCO_CTRL_PFM];
	wire pol       = ctrl[nco_pkg::NCO_CTRL_POL];
	wire [2:0] pws = clkcfg[nco_pkg::NCO_CLK_PWS_LSB +: 3];
	wire [1:0] src = clkcfg[nco_pkg::NCO_CLK_SRC_LSB +: 2];

	// source clock tick; kept running regardless of sleep
	wire tick = en && (div_cnt == srcdiv);
	wire [ACC_W:0] sum = {1'b0, acc} + {1'b0, inc};
	wire ovf = tick && sum[ACC_W];
	wire pulse_active;

	nco_pulse_timer u_timer (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (tick),
		.start     (ovf && pfm),
		.width_sel (pws),
		.active    (pulse_active)
	);

	// fixed duty: toggle register; pulse: timer level
	wire raw_next = pfm ? pulse_active : (raw_q ^ (ovf && !pfm));
	wire out_lvl  = raw_q ^ pol;
	wire pol_chg  = (pol != pol_d) && (out_lvl != nco_output);

	wire sel_ctrl = avs_address == nco_pkg::NCO_ADDR_CTRL;
	wire sel_clk  = avs_address == nco_pkg::NCO_ADDR_CLKCFG;
	wire sel_inc  = avs_address == nco_pkg::NCO_ADDR_INC;
	wire sel_acc  = avs_address == nco_pkg::NCO_ADDR_ACC;
	wire sel_ist  = avs_address == nco_pkg::NCO_ADDR_IRQST;
	wire sel_ien  = avs_address == nco_pkg::NCO_ADDR_IRQEN;
	wire sel_ictl = avs_address == nco_pkg::NCO_ADDR_INTCTL;
	wire sel_apf  = avs_address == nco_pkg::NCO_ADDR_APF;
	wire sel_div  = avs_address == nco_pkg::NCO_ADDR_SRCDIV;
	// a write lands only at the edge where waitrequest is seen low
	wire do_wr    = avs_write && ack;
	wire do_rd    = avs_read && !ack;

	// sticky flags: write one clears, a new event wins over the clear
	wire [1:0] ist_clr = (do_wr && sel_ist) ? avs_writedata[1:0] : 2'b00;
	wire [1:0] ist_set = {pol_chg && irq_en[nco_pkg::NCO_IRQ_POL], ovf};
	wire [1:0] next_irq_st = (irq_st & ~ist_clr) | ist_set;
	wire next_irq = en && intctl[nco_pkg::NCO_INT_GIE] && intctl[nco_pkg::NCO_INT_PERIPHERAL_IRQ_ENABLE]
		&& |(next_irq_st & irq_en);

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl)
			rd_mux[7:0] = {ctrl[7:6], nco_output, ctrl[4:0]};
		else if (sel_clk)
			rd_mux[7:0] = clkcfg;
		else if (sel_inc)
			rd_mux[ACC_W-1:0] = inc;
		else if (sel_acc)
			rd_mux[ACC_W-1:0] = acc;
		else if (sel_ist)
			rd_mux[1:0] = irq_st;
		else if (sel_ien)
			rd_mux[1:0] = irq_en;
		else if (sel_ictl)
			rd_mux[7:0] = intctl;
		else if (sel_apf)
			rd_mux[0] = apf;
		else if (sel_div)
			rd_mux[7:0] = srcdiv;
	end

	// one wait cycle per access; unmapped reads return zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack          <= 1'b0;
			avs_readdata <= nco_pkg::NCO_RST_WORD;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
			if (do_rd)
				avs_readdata <= rd_mux;
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl   <= nco_pkg::NCO_RST_BYTE;
			clkcfg <= nco_pkg::NCO_RST_BYTE;
			inc    <= '0;
			intctl <= nco_pkg::NCO_RST_BYTE;
			irq_en <= 2'b00;
			apf    <= 1'b0;
			srcdiv <= nco_pkg::NCO_RST_BYTE;
		end else if (do_wr) begin
			if (sel_ctrl)
				ctrl <= {avs_writedata[7:6], 1'b0, avs_writedata[4:0]};
			if (sel_clk)
				clkcfg <= avs_writedata[7:0];
			if (sel_inc)
				inc <= avs_writedata[ACC_W-1:0];
			if (sel_ictl)
				intctl <= avs_writedata[7:0];
			if (sel_ien)
				irq_en <= avs_writedata[1:0];
			if (sel_apf)
				apf <= avs_writedata[0];
			if (sel_div)
				srcdiv <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= nco_pkg::NCO_RST_BYTE;
			acc     <= '0;
			raw_q   <= 1'b0;
			pol_d   <= 1'b0;
			irq_st  <= 2'b00;
			irq     <= 1'b0;
		end else begin
			div_cnt <= (!en || tick) ? 8'h00 : div_cnt + 8'h01;
			if (!en)
				acc <= '0;
			else if (tick)
				acc <= sum[ACC_W-1:0];
			raw_q  <= en ? raw_next : 1'b0;
			pol_d  <= pol;
			irq_st <= next_irq_st;
			irq    <= next_irq;
		end
	end

	// outputs, registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			nco_output           <= 1'b0;
			nco_to_logic_cell    <= 1'b0;
			nco_to_waveform_unit <= 1'b0;
			nco_pin_primary      <= 1'b0;
			nco_pin_alternate    <= 1'b0;
			hf_osc_keep_on       <= 1'b0;
		end else begin
			nco_output           <= out_lvl;
			nco_to_logic_cell    <= out_lvl;
			nco_to_waveform_unit <= out_lvl;
			nco_pin_primary      <= apf ? 1'b0 : out_lvl;
			nco_pin_alternate    <= apf ? out_lvl : 1'b0;
			hf_osc_keep_on       <= en && (src == nco_pkg::NCO_SRC_HFINT);
		end
	end

	// sleep_mode only documents intent; the block never gates on it
	wire unused_sleep = sleep_mode;

	property p_ovf_flag;
		@(posedge clk_sys) disable iff (!rst_n) ovf |=> irq_st[0];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

	property p_flag_sticky;
		@(posedge clk_sys) disable iff (!rst_n)
			irq_st[0] && !(do_wr && sel_ist && avs_writedata[0]) |=> irq_st[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

	property p_fdc_toggle;
		@(posedge clk_sys) disable iff (!rst_n)
			en && !pfm && ovf && $stable(pol) |=> ##1 (nco_output != $past(nco_output));
	endproperty
	a_fdc_toggle: assert property (p_fdc_toggle) else $error("no toggle on overflow");

	sequence s_pulse_start;
		en && pfm && ovf && !pulse_active;
	endsequence
	property p_pf_active;
		@(posedge clk_sys) disable iff (!rst_n) s_pulse_start |=> pulse_active;
	endproperty
	a_pf_active: assert property (p_pf_active) else $error("pulse not started");

	property p_pf_level;
		@(posedge clk_sys) disable iff (!rst_n)
			en && pfm && $stable(pfm) |=> raw_q == $past(pulse_active);
	endproperty
	a_pf_level: assert property (p_pf_level) else $error("pulse level wrong");

	property p_pol;
		@(posedge clk_sys) disable iff (!rst_n) 1'b1 |=> nco_output == ($past(raw_q) ^ $past(pol));
	endproperty
	a_pol: assert property (p_pol) else $error("polarity stage wrong");

	property p_irq_gate;
		@(posedge clk_sys) disable iff (!rst_n)
			irq |-> $past(en) && $past(intctl[nco_pkg::NCO_INT_GIE]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

	property p_ctrl_read;
		@(posedge clk_sys) disable iff (!rst_n)
			do_rd && sel_ctrl |=> avs_readdata[nco_pkg::NCO_CTRL_OUT] == $past(nco_output);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("output bit misread");

	// pulse mode: level follows the timer, two edges behind the overflow tick
	sequence s_pf_ovf;
		en && pfm && ovf;
	endsequence
	property p_pf_out;
		@(posedge clk_sys) disable iff (!rst_n)
			s_pf_ovf ##1 (en && pfm) |=> raw_q;
	endproperty
	a_pf_out: assert property (p_pf_out) else $error("pulse late");

	property p_pf_idle;
		@(posedge clk_sys) disable iff (!rst_n)
			en && pfm && !pulse_active |=> !raw_q;
	endproperty
	a_pf_idle: assert property (p_pf_idle) else $error("pulse not ended");

	property p_irq_needs_en;
		@(posedge clk_sys) disable iff (!rst_n)
			!en |=> !irq;
	endproperty
	a_irq_needs_en: assert property (p_irq_needs_en) else $error("irq while off");

	property p_irq_needs_peripheral_irq_enable;
		@(posedge clk_sys) disable iff (!rst_n)
			!intctl[nco_pkg::NCO_INT_PERIPHERAL_IRQ_ENABLE] |=> !irq;
	endproperty
	a_irq_needs_peripheral_irq_enable: assert property (p_irq_needs_peripheral_irq_enable) else $error("irq no peripheral");

	property p_irq_needs_ie;
		@(posedge clk_sys) disable iff (!rst_n)
			irq_en == 2'b00 |=> !irq;
	endproperty
	a_irq_needs_ie: assert property (p_irq_needs_ie) else $error("irq while masked");

	property p_pol_flag;
		@(posedge clk_sys) disable iff (!rst_n)
			$changed(pol) && ((raw_q ^ pol) != nco_output) && irq_en[nco_pkg::NCO_IRQ_POL]
			|=> irq_st[nco_pkg::NCO_IRQ_POL];
	endproperty
	a_pol_flag: assert property (p_pol_flag) else $error("polarity flag missing");

	property p_pol_sticky;
		@(posedge clk_sys) disable iff (!rst_n)
			irq_st[1] && !(do_wr && sel_ist && avs_writedata[1]) |=> irq_st[1];
	endproperty
	a_pol_sticky: assert property (p_pol_sticky) else $error("polarity flag dropped");

	property p_ovf_clear;
		@(posedge clk_sys) disable iff (!rst_n)
			do_wr && sel_ist && avs_writedata[0] && !ovf |=> !irq_st[0];
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("flag not cleared");

	property p_copies;
		@(posedge clk_sys) disable iff (!rst_n)
			nco_to_logic_cell == nco_output && nco_to_waveform_unit == nco_output;
	endproperty
	a_copies: assert property (p_copies) else $error("consumer copy differs");

	property p_pin_alt;
		@(posedge clk_sys) disable iff (!rst_n)
			apf |=> !nco_pin_primary && (nco_pin_alternate == nco_output);
	endproperty
	a_pin_alt: assert property (p_pin_alt) else $error("alternate pin wrong");

	property p_pin_pri;
		@(posedge clk_sys) disable iff (!rst_n)
			!apf |=> !nco_pin_alternate && (nco_pin_primary == nco_output);
	endproperty
	a_pin_pri: assert property (p_pin_pri) else $error("primary pin wrong");

	property p_hf_keep;
		@(posedge clk_sys) disable iff (!rst_n)
			en && (src == nco_pkg::NCO_SRC_HFINT) |=> hf_osc_keep_on;
	endproperty
	a_hf_keep: assert property (p_hf_keep) else $error("hf source dropped");

	property p_acc_step;
		@(posedge clk_sys) disable iff (!rst_n)
			en && tick |=> acc == ACC_W'($past(acc) + $past(inc));
	endproperty
	a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

	// divided source: no two ticks in a row unless the divider is zero
	property p_tick_gap;
		@(posedge clk_sys) disable iff (!rst_n)
			tick && (srcdiv != 8'h00) |=> !tick || (srcdiv == 8'h00);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("source tick too fast");

	property p_reset_clear;
		@(posedge clk_sys) disable iff (!rst_n)
			$rose(rst_n) |-> ctrl == 8'h00 && irq_st == 2'b00 && acc == '0 && !nco_output;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("state left after reset");

	property p_pws_write;
		@(posedge clk_sys) disable iff (!rst_n)
			avs_write && !avs_waitrequest && sel_clk |=> pws == $past(avs_writedata[7:5]);
	endproperty
	a_pws_write: assert property (p_pws_write) else $error("width field not written");
endmodule : nco_out

// file: nco_sink_model.sv
// model of the internal consumers of the oscillator output
`timescale 1ns/100ps
module nco_sink_model (
	input  wire logic  clk_sys,
	input  wire logic  arst_n,
	input  wire logic  logic_cell_in,
	input  wire logic  waveform_in,
	output logic [15:0] skew_cnt
);
	// both consumers must see the same level in every cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			skew_cnt <= 16'h0000;
		end else if (logic_cell_in !== waveform_in) begin
			skew_cnt <= skew_cnt + 16'h0001;
		end
	end
endmodule : nco_sink_model

// file: tb.sv
// self-checking bench for the oscillator output stage
`timescale 1ns/100ps
module tb;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        sleep_mode = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, nco_output, nco_to_logic_cell, nco_to_waveform_unit;
	logic        nco_pin_primary, nco_pin_alternate, hf_osc_keep_on, irq;
	logic [15:0] skew_cnt;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;
	always #20 clk_sys = ~clk_sys;
	nco_out #(.ACC_W(20)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .sleep_mode(sleep_mode),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nco_output(nco_output),
		.nco_to_logic_cell(nco_to_logic_cell), .nco_to_waveform_unit(nco_to_waveform_unit),
		.nco_pin_primary(nco_pin_primary), .nco_pin_alternate(nco_pin_alternate),
		.hf_osc_keep_on(hf_osc_keep_on), .irq(irq));
	nco_sink_model sink (.clk_sys(clk_sys), .arst_n(arst_n), .logic_cell_in(nco_to_logic_cell),
		.waveform_in(nco_to_waveform_unit), .skew_cnt(skew_cnt));
	task finish_test;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// holds the request until waitrequest is sampled low, then releases
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, q, exp);
	endtask : rd_chk
	// 40 cycles hold a whole number of periods, so phase does not matter
	task high_count(input string what, input logic [31:0] exp);
		int h;
		h = 0;
		repeat (8) @(posedge clk_sys);
		repeat (40) begin
			@(posedge clk_sys);
			if (nco_output === 1'b1) h++;
		end
		chk(what, h, exp);
	endtask : high_count
	task test_reset_values;
		for (int a = 0; a < 9; a++) begin
			rd_chk("reset reg", a[3:0], nco_pkg::NCO_RST_WORD);
		end
		rd_chk("unmapped", 4'hf, 32'h0000_0000);
		$display("test reset_values done");
	endtask : test_reset_values
	task test_fixed_duty;
		wr(nco_pkg::NCO_ADDR_INC, 32'h0008_0000);
		wr(nco_pkg::NCO_ADDR_CTRL, 32'h0000_0080);
		high_count("fixed duty highs", 32'd20);
		chk("keep hf on", hf_osc_keep_on, 32'h1);
		$display("test fixed_duty done");
	endtask : test_fixed_duty
	task test_pulse_width;
		wr(nco_pkg::NCO_ADDR_INC, 32'h0004_0000);
		wr(nco_pkg::NCO_ADDR_CTRL, 32'h0000_0081);
		high_count("pulse width 1", 32'd10);
		wr(nco_pkg::NCO_ADDR_CLKCFG, 32'h0000_0020); // 2 periods fit the 4-tick interval
		high_count("pulse width 2", 32'd20);
		$display("test pulse_width done");
	endtask : test_pulse_width
	task test_flag_irq;
		wr(nco_pkg::NCO_ADDR_INC, 32'h0000_0000);
		repeat (8) @(posedge clk_sys);
		chk("idle level", nco_output, 32'h0);
		rd_chk("overflow flag", nco_pkg::NCO_ADDR_IRQST, 32'h0000_0001);
		wr(nco_pkg::NCO_ADDR_IRQEN, 32'h0000_0001);
		wr(nco_pkg::NCO_ADDR_INTCTL, 32'h0000_00c0);
		repeat (4) @(posedge clk_sys);
		chk("irq raised", irq, 32'h1);
		rd_chk("flag sticky", nco_pkg::NCO_ADDR_IRQST, 32'h0000_0001);
		wr(nco_pkg::NCO_ADDR_INTCTL, 32'h0000_0040);
		repeat (4) @(posedge clk_sys);
		chk("irq no global", irq, 32'h0);
		wr(nco_pkg::NCO_ADDR_INTCTL, 32'h0000_00c0);
		wr(nco_pkg::NCO_ADDR_IRQST, 32'h0000_0001);
		repeat (4) @(posedge clk_sys);
		chk("irq cleared", irq, 32'h0);
		rd_chk("flag cleared", nco_pkg::NCO_ADDR_IRQST, 32'h0000_0000);
		$display("test flag_irq done");
	endtask : test_flag_irq
	task test_polarity_pins;
		wr(nco_pkg::NCO_ADDR_IRQEN, 32'h0000_0002);
		wr(nco_pkg::NCO_ADDR_CTRL, 32'h0000_0091);
		repeat (4) @(posedge clk_sys);
		chk("inverted idle", nco_output, 32'h1);
		chk("polarity irq", irq, 32'h1);
		rd_chk("polarity status", nco_pkg::NCO_ADDR_IRQST, 32'h0000_0002);
		rd_chk("state bit", nco_pkg::NCO_ADDR_CTRL, 32'h0000_00b1);
		chk("primary pin", {nco_pin_primary, nco_pin_alternate}, 32'h2);
		wr(nco_pkg::NCO_ADDR_APF, 32'h0000_0001);
		repeat (4) @(posedge clk_sys);
		chk("alternate pin", {nco_pin_primary, nco_pin_alternate}, 32'h1);
		chk("cell copy", nco_to_logic_cell, 32'h1);
		chk("consumer skew", skew_cnt, 32'h0);
		$display("test polarity_pins done");
	endtask : test_polarity_pins
	task test_divider;
		wr(nco_pkg::NCO_ADDR_INC, 32'h0008_0000);
		rd_chk("increment", nco_pkg::NCO_ADDR_INC, 32'h0008_0000);
		wr(nco_pkg::NCO_ADDR_SRCDIV, 32'h0000_0001);
		wr(nco_pkg::NCO_ADDR_CLKCFG, 32'h0000_0001);
		wr(nco_pkg::NCO_ADDR_CTRL, 32'h0000_0080);
		high_count("divided duty highs", 32'd20);
		chk("keep hf off", hf_osc_keep_on, 32'h0);
		$display("test divider done");
	endtask : test_divider
	task test_mid_reset;
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("output in reset", nco_output, 32'h0);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd_chk("ctrl after reset", nco_pkg::NCO_ADDR_CTRL, 32'h0000_0000);
		rd_chk("apf after reset", nco_pkg::NCO_ADDR_APF, 32'h0000_0000);
		$display("test mid_reset done");
	endtask : test_mid_reset
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		sleep_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		test_reset_values;
		test_fixed_duty;
		test_pulse_width;
		test_flag_irq;
		test_polarity_pins;
		test_divider;
		test_mid_reset;
		finish_test;
	end
endmodule : tb
